// >>> hw/feac_tx_pkg.sv
// Purpose: Shared constants and types of the FEAC transmit codeword generator
// Assumes: 32-bit AHB-Lite register port, one word per register index
// Notes:   Printed offsets are register indices; byte address is four times the index
package feac_tx_pkg;

    // Register indices and byte addresses
    localparam logic [11:0] IDX_CONTROL = 12'h0c0;
    localparam logic [11:0] IDX_CODES = 12'h0c2;
    localparam logic [11:0] IDX_STATUS = 12'h0c4;
    localparam logic [11:0] IDX_STICKY = 12'h0c6;
    localparam logic [11:0] IDX_IRQ_EN = 12'h0c8;
    localparam logic [11:0] ADDR_CONTROL = {IDX_CONTROL[9:0], 2'h0};
    localparam logic [11:0] ADDR_CODES = {IDX_CODES[9:0], 2'h0};
    localparam logic [11:0] ADDR_STATUS = {IDX_STATUS[9:0], 2'h0};
    localparam logic [11:0] ADDR_STICKY = {IDX_STICKY[9:0], 2'h0};
    localparam logic [11:0] ADDR_IRQ_EN = {IDX_IRQ_EN[9:0], 2'h0};

    // Field positions
    localparam int LOAD_BIT = 2;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;
    localparam int CODE_W = 6;
    localparam int CODE_A_LSB = 0;
    localparam int CODE_B_LSB = 8;
    localparam int IDLE_BIT = 0;
    localparam int HTRANS_ACTIVE_BIT = 1;

    // Reset values
    localparam logic [MODE_W-1:0] MODE_RESET = 2'h0;
    localparam logic [CODE_W-1:0] CODE_RESET = 6'h00;
    localparam logic STICKY_RESET = 1'b1;

    // Sequencing counts
    localparam logic [3:0] REPEAT_LAST = 4'h9;
    localparam logic [3:0] FRAME_LAST = 4'hf;
    localparam logic [3:0] FRAME_CODE_END = 4'h6;
    localparam logic [3:0] FRAME_ZERO2 = 4'h7;
    localparam logic [7:0] FRAME_ONES = 8'hff;

    // Which bit of the global port enable field belongs to this port
    localparam logic [1:0] PORT_NUM = 2'h0;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'h0,
        MODE_SINGLE = 2'h1,
        MODE_DUAL = 2'h2,
        MODE_CONT = 2'h3
    } mode_t;

    // Gray order along the path idle, code A, code B
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SEND_A = 2'h1,
        ST_SEND_B = 2'h3,
        ST_CONT = 2'h2
    } state_t;

endpackage

// >>> hw/feac_ser_if.sv
// Purpose: Link between the codeword sequencer and the bit serializer
// Assumes: Single clock domain
// Notes:   start and abort are one-cycle pulses, done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface feac_ser_if;
    logic start;
    logic abort;
    logic [5:0] code;
    logic done;
    logic busy;
    logic tx_bit;
    modport seq (output start, output abort, output code,
                 input done, input busy, input tx_bit);
    modport ser (input start, input abort, input code,
                 output done, output busy, output tx_bit);
endinterface
`default_nettype wire

// >>> hw/feac_serializer.sv
// Purpose: Serialise one sixteen-bit FEAC codeword onto the overhead bit slots
// Assumes: slot is a one-cycle pulse, at least three cycles apart
// Notes:   Outside a codeword every slot carries a one
`timescale 1ns/1ps
`default_nettype none
module feac_serializer (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Framer slot strobe
    input wire logic slot,
    // Sequencer side
    feac_ser_if.ser sif
);

    logic [15:0] frame_q;
    logic [3:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Frame shifter: zero, six code bits first-bit-first, zero, eight ones
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_q <= 16'hffff;
            cnt_q <= 4'h0;
            sif.busy <= 1'b0;
            sif.done <= 1'b0;
        end else begin
            sif.done <= 1'b0;
            if (sif.start) begin
                frame_q <= {feac_tx_pkg::FRAME_ONES, 1'b0, sif.code, 1'b0};
                cnt_q <= 4'h0;
                sif.busy <= 1'b1;
            end else if (sif.abort) begin
                sif.busy <= 1'b0;
                cnt_q <= 4'h0;
            end else if (sif.busy && slot) begin
                frame_q <= {1'b1, frame_q[15:1]};
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == feac_tx_pkg::FRAME_LAST) begin
                    sif.busy <= 1'b0;
                    sif.done <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line bit changes only on a slot; idle slots carry ones
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sif.tx_bit <= 1'b1;
        end else if (slot) begin
            sif.tx_bit <= sif.busy ? frame_q[0] : 1'b1;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_frame_zeros: assert property (sif.busy && slot && !sif.start && !sif.abort
        && (cnt_q == 4'h0 || cnt_q == feac_tx_pkg::FRAME_ZERO2) |=> !sif.tx_bit)
        else $error("framing zero not sent");
    a_frame_ones: assert property (slot && !sif.start && !sif.abort
        && (!sif.busy || cnt_q > feac_tx_pkg::FRAME_ZERO2) |=> sif.tx_bit)
        else $error("framing one not sent");
    a_code_order: assert property (sif.start
        |=> frame_q[6:1] == $past(sif.code) && frame_q[0] == 1'b0)
        else $error("code bits not loaded first bit first");

endmodule
`default_nettype wire

// >>> hw/feac_tx_gen.sv
// Purpose: FEAC transmit codeword generator with AHB-Lite register port
// Assumes: feac_slot marks each FEAC overhead bit slot of the transmit framer
// Notes:   Zero-wait slave; reads of unmapped addresses return zero, writes are dropped
`timescale 1ns/1ps
`default_nettype none
module feac_tx_gen (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Framer overhead insertion
    input wire logic feac_slot,
    output logic feac_bit,
    // Interrupt
    input wire logic [3:0] global_port_irq_enables,
    output logic irq
);

    feac_ser_if sif ();

    // Software-visible registers
    logic load_q;
    logic [feac_tx_pkg::MODE_W-1:0] tx_code_mode_select_q;
    logic [feac_tx_pkg::CODE_W-1:0] first_code_field_q;
    logic [feac_tx_pkg::CODE_W-1:0] second_code_field_q;
    logic tx_idle_irq_en_q;
    logic tx_idle_sticky_q;
    logic tx_idle_live_q;

    // Bus data-phase capture
    logic wr_pend_q;
    logic [11:0] wr_addr_q;

    // Active setup and sequencer
    logic load_prev_q;
    logic codeword_load_strobe;
    feac_tx_pkg::mode_t act_mode_q;
    logic [feac_tx_pkg::CODE_W-1:0] act_a_q;
    logic [feac_tx_pkg::CODE_W-1:0] act_b_q;
    feac_tx_pkg::state_t state_q;
    logic [3:0] rep_q;
    logic start_q;
    logic abort_q;
    logic [feac_tx_pkg::CODE_W-1:0] code_q;
    logic live_d;

    logic addr_ok;
    logic [11:0] addr_lo;
    logic wr_control;
    logic wr_codes;
    logic wr_sticky;
    logic wr_irq_en;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase and read data
    assign addr_ok = hsel && hready && htrans[feac_tx_pkg::HTRANS_ACTIVE_BIT];
    assign addr_lo = haddr[11:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr_q <= addr_lo;
            end
            if (addr_ok && !hwrite) begin
                case (addr_lo)
                    feac_tx_pkg::ADDR_CONTROL: begin
                        hrdata <= {29'h0000_0000, load_q, tx_code_mode_select_q};
                    end
                    feac_tx_pkg::ADDR_CODES: begin
                        hrdata <= {18'h0_0000, second_code_field_q, 2'h0,
                                   first_code_field_q};
                    end
                    feac_tx_pkg::ADDR_STATUS: begin
                        hrdata <= {31'h0000_0000, tx_idle_live_q};
                    end
                    feac_tx_pkg::ADDR_STICKY: begin
                        hrdata <= {31'h0000_0000, tx_idle_sticky_q};
                    end
                    feac_tx_pkg::ADDR_IRQ_EN: begin
                        hrdata <= {31'h0000_0000, tx_idle_irq_en_q};
                    end
                    default: begin
                        hrdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Writes land in the data phase; hsize is ignored as only words are used
    assign wr_control = wr_pend_q && wr_addr_q == feac_tx_pkg::ADDR_CONTROL;
    assign wr_codes = wr_pend_q && wr_addr_q == feac_tx_pkg::ADDR_CODES;
    assign wr_sticky = wr_pend_q && wr_addr_q == feac_tx_pkg::ADDR_STICKY;
    assign wr_irq_en = wr_pend_q && wr_addr_q == feac_tx_pkg::ADDR_IRQ_EN;

    ////////////////////////////////////////////////////////////////////////////
    // Control, code and enable registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_q <= 1'b0;
            tx_code_mode_select_q <= feac_tx_pkg::MODE_RESET;
            first_code_field_q <= feac_tx_pkg::CODE_RESET;
            second_code_field_q <= feac_tx_pkg::CODE_RESET;
            tx_idle_irq_en_q <= 1'b0;
        end else begin
            if (wr_control) begin
                load_q <= hwdata[feac_tx_pkg::LOAD_BIT];
                tx_code_mode_select_q <=
                    hwdata[feac_tx_pkg::MODE_LSB +: feac_tx_pkg::MODE_W];
            end
            if (wr_codes) begin
                first_code_field_q <=
                    hwdata[feac_tx_pkg::CODE_A_LSB +: feac_tx_pkg::CODE_W];
                second_code_field_q <=
                    hwdata[feac_tx_pkg::CODE_B_LSB +: feac_tx_pkg::CODE_W];
            end
            if (wr_irq_en) begin
                tx_idle_irq_en_q <= hwdata[feac_tx_pkg::IDLE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Load edge: only a 0 to 1 change of the stored bit loads a new setup
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_prev_q <= 1'b0;
        end else begin
            load_prev_q <= load_q;
        end
    end

    assign codeword_load_strobe = load_q && !load_prev_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_mode_q <= feac_tx_pkg::MODE_IDLE;
            act_a_q <= feac_tx_pkg::CODE_RESET;
            act_b_q <= feac_tx_pkg::CODE_RESET;
        end else if (codeword_load_strobe) begin
            act_mode_q <= feac_tx_pkg::mode_t'(tx_code_mode_select_q);
            act_a_q <= first_code_field_q;
            act_b_q <= second_code_field_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: decides which code goes next and how often
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= feac_tx_pkg::ST_IDLE;
            rep_q <= 4'h0;
            start_q <= 1'b0;
            abort_q <= 1'b0;
            code_q <= feac_tx_pkg::CODE_RESET;
        end else begin
            start_q <= 1'b0;
            abort_q <= 1'b0;
            if (codeword_load_strobe) begin
                // Loads take effect at once, cutting short any codeword on the line
                rep_q <= 4'h0;
                code_q <= first_code_field_q;
                case (feac_tx_pkg::mode_t'(tx_code_mode_select_q))
                    feac_tx_pkg::MODE_IDLE: begin
                        state_q <= feac_tx_pkg::ST_IDLE;
                        abort_q <= 1'b1;
                    end
                    feac_tx_pkg::MODE_CONT: begin
                        state_q <= feac_tx_pkg::ST_CONT;
                        start_q <= 1'b1;
                    end
                    default: begin
                        state_q <= feac_tx_pkg::ST_SEND_A;
                        start_q <= 1'b1;
                    end
                endcase
            end else if (sif.done) begin
                case (state_q)
                    feac_tx_pkg::ST_SEND_A: begin
                        if (rep_q != feac_tx_pkg::REPEAT_LAST) begin
                            rep_q <= rep_q + 4'h1;
                            start_q <= 1'b1;
                            code_q <= act_a_q;
                        end else if (act_mode_q == feac_tx_pkg::MODE_DUAL) begin
                            rep_q <= 4'h0;
                            state_q <= feac_tx_pkg::ST_SEND_B;
                            start_q <= 1'b1;
                            code_q <= act_b_q;
                        end else begin
                            state_q <= feac_tx_pkg::ST_IDLE;
                        end
                    end
                    feac_tx_pkg::ST_SEND_B: begin
                        if (rep_q != feac_tx_pkg::REPEAT_LAST) begin
                            rep_q <= rep_q + 4'h1;
                            start_q <= 1'b1;
                            code_q <= act_b_q;
                        end else begin
                            state_q <= feac_tx_pkg::ST_IDLE;
                        end
                    end
                    feac_tx_pkg::ST_CONT: begin
                        start_q <= 1'b1;
                        code_q <= act_a_q;
                    end
                    default: begin
                        state_q <= feac_tx_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign sif.start = start_q;
    assign sif.abort = abort_q;
    assign sif.code = code_q;

    feac_serializer u_ser (
        .hclk(hclk),
        .hresetn(hresetn),
        .slot(feac_slot),
        .sif(sif)
    );

    assign feac_bit = sif.tx_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Idle status, sticky flag and interrupt
    // A pending start counts as sending, so a restart never flickers to idle
    assign live_d = state_q == feac_tx_pkg::ST_IDLE && !sif.busy && !start_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_idle_live_q <= 1'b1;
        end else begin
            tx_idle_live_q <= live_d;
        end
    end

    // The set wins over a clear arriving in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_idle_sticky_q <= feac_tx_pkg::STICKY_RESET;
        end else if (live_d && !tx_idle_live_q) begin
            tx_idle_sticky_q <= 1'b1;
        end else if (wr_sticky && hwdata[feac_tx_pkg::IDLE_BIT]) begin
            tx_idle_sticky_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= tx_idle_sticky_q && tx_idle_irq_en_q
                   && global_port_irq_enables[feac_tx_pkg::PORT_NUM];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_load;
        codeword_load_strobe;
    endsequence

    sequence s_last_a;
        sif.done && state_q == feac_tx_pkg::ST_SEND_A && rep_q == feac_tx_pkg::REPEAT_LAST;
    endsequence

    a_load_capture: assert property (s_load
        |=> act_mode_q == $past(tx_code_mode_select_q)
        && act_a_q == $past(first_code_field_q) && act_b_q == $past(second_code_field_q))
        else $error("load did not capture setup");
    a_load_restart: assert property (s_load ##1 (state_q != feac_tx_pkg::ST_IDLE)
        |-> start_q ##1 sif.busy)
        else $error("load did not restart transmission");
    a_idle_abort: assert property (s_load ##1 (state_q == feac_tx_pkg::ST_IDLE)
        |-> abort_q ##1 !sif.busy)
        else $error("idle load did not stop codeword");
    a_single_ends: assert property (s_last_a
        ##0 act_mode_q == feac_tx_pkg::MODE_SINGLE
        |=> state_q == feac_tx_pkg::ST_IDLE && !start_q)
        else $error("single mode did not return to idle");
    a_dual_next: assert property (s_last_a ##0 act_mode_q == feac_tx_pkg::MODE_DUAL
        |=> state_q == feac_tx_pkg::ST_SEND_B && start_q && code_q == act_b_q && rep_q == 4'h0)
        else $error("dual mode did not move to code B");
    a_cont_repeat: assert property (state_q == feac_tx_pkg::ST_CONT && sif.done
        && !codeword_load_strobe |=> start_q && code_q == act_a_q)
        else $error("continuous mode stopped repeating");
    a_live_busy: assert property (sif.busy |=> !tx_idle_live_q)
        else $error("idle reported while sending");
    a_sticky_rise: assert property ($rose(tx_idle_live_q) |-> tx_idle_sticky_q)
        else $error("sticky idle flag missed a rise");
    a_sticky_clear: assert property (wr_sticky && hwdata[feac_tx_pkg::IDLE_BIT]
        && !(live_d && !tx_idle_live_q) |=> !tx_idle_sticky_q)
        else $error("write one did not clear sticky flag");
    a_irq_gate: assert property (irq
        |-> $past(tx_idle_sticky_q) && $past(tx_idle_irq_en_q)
        && $past(global_port_irq_enables[feac_tx_pkg::PORT_NUM]))
        else $error("interrupt raised without all enables");

endmodule
`default_nettype wire

// >>> bench/feac_framer_model.sv
// Purpose: Framer model that strobes FEAC slots and collects the bits sent
// Assumes: One slot every four cycles, above the minimum spacing of three
// Notes:   window holds the last sixteen bits, oldest in bit 15
`timescale 1ns/1ps
`default_nettype none
module feac_framer_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Overhead bit stream
    input wire logic feac_bit,
    output logic feac_slot,
    // Collected bits
    output logic [15:0] window,
    output logic window_new
);
    logic [1:0] div_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    assign feac_slot = (div_q == 2'h3);
    ////////////////////////////////////////////////////////////////////
    // The bit of the previous slot stands until this slot edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            window <= 16'hffff;
            window_new <= 1'b0;
        end else begin
            window_new <= feac_slot;
            if (feac_slot) begin
                window <= {window[14:0], feac_bit};
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Purpose: Register-level test of the FEAC transmit codeword generator
// Assumes: Zero-wait slave, hready fed from hreadyout
// Notes:   Codewords are counted by matching the framer model's window
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] gpe = 4'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic feac_slot;
    logic feac_bit;
    logic window_new;
    logic [31:0] hrdata;
    logic [31:0] rv;
    logic [15:0] window;
    logic [15:0] pa = 16'h0;
    logic [15:0] pb = 16'h0;
    int bad_count = 0;
    int tests_run = 0;
    int na = 0;
    int nb = 0;
    assign hready = hreadyout;
    always #20 hclk = ~hclk;
    feac_tx_gen dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .feac_slot(feac_slot),
        .feac_bit(feac_bit), .global_port_irq_enables(gpe), .irq(irq));
    feac_framer_model partner (.hclk(hclk), .hresetn(hresetn), .feac_bit(feac_bit),
        .feac_slot(feac_slot), .window(window), .window_new(window_new));
    always @(posedge hclk) begin
        if (window_new === 1'b1 && window === pa) na++;
        if (window_new === 1'b1 && window === pb) nb++;
    end
    ////////////////////////////////////////////////////////////////////
    // Zero, C1..C6 with field bit 0 first, zero, eight ones
    function automatic logic [15:0] pat(input logic [5:0] c);
        return {1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0, 8'hff};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rv = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask
    task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(n, rv, exp);
    endtask
    // Load bit is cleared first so the next write gives a rising edge
    task automatic load(input logic [1:0] m, input logic [5:0] a, input logic [5:0] b);
        pa = pat(a);
        pb = pat(b);
        xfer(feac_tx_pkg::ADDR_CODES, 1'b1, {18'h0, b, 2'h0, a});
        xfer(feac_tx_pkg::ADDR_CONTROL, 1'b1, {30'h0, m});
        na = 0;
        nb = 0;
        xfer(feac_tx_pkg::ADDR_CONTROL, 1'b1, {29'h0, 1'b1, m});
        repeat (2) @(posedge hclk); // Live idle falls two edges after the load lands
    endtask
    task automatic wait_idle;
        rv = 32'h0;
        for (int i = 0; i < 1000 && rv[0] !== 1'b1; i++) xfer(feac_tx_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk("idle wait", rv, 32'h1);
        repeat (8) @(posedge hclk);
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge hclk);
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk("status", feac_tx_pkg::ADDR_STATUS, 32'h1);
        rdchk("sticky", feac_tx_pkg::ADDR_STICKY, 32'h1);
        rdchk("irq_en", feac_tx_pkg::ADDR_IRQ_EN, 32'h0);
        rdchk("control", feac_tx_pkg::ADDR_CONTROL, 32'h0);
        rdchk("codes", feac_tx_pkg::ADDR_CODES, 32'h0);
        rdchk("unmapped", 12'h304, 32'h0);
        xfer(feac_tx_pkg::ADDR_STICKY, 1'b1, 32'h0);
        rdchk("sticky w0", feac_tx_pkg::ADDR_STICKY, 32'h1);
        xfer(feac_tx_pkg::ADDR_STICKY, 1'b1, 32'h1);
        rdchk("sticky w1", feac_tx_pkg::ADDR_STICKY, 32'h0);
        load(2'h1, 6'h16, 6'h2d);
        rdchk("busy", feac_tx_pkg::ADDR_STATUS, 32'h0);
        wait_idle();
        chk("single a", 32'(na), 32'd10);
        chk("single b", 32'(nb), 32'd0);
        rdchk("sticky set", feac_tx_pkg::ADDR_STICKY, 32'h1);
        gpe <= 4'h1;
        repeat (3) @(posedge hclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        xfer(feac_tx_pkg::ADDR_IRQ_EN, 1'b1, 32'h1);
        repeat (3) @(posedge hclk);
        chk("irq on", {31'h0, irq}, 32'h1);
        gpe <= 4'h2;
        repeat (3) @(posedge hclk);
        chk("irq other port", {31'h0, irq}, 32'h0);
        gpe <= 4'h1;
        xfer(feac_tx_pkg::ADDR_STICKY, 1'b1, 32'h1);
        repeat (3) @(posedge hclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        load(2'h2, 6'h0b, 6'h34);
        wait_idle();
        chk("dual a", 32'(na), 32'd10);
        chk("dual b", 32'(nb), 32'd10);
        rdchk("codes rb", feac_tx_pkg::ADDR_CODES, 32'h0000_340b);
        rdchk("control rb", feac_tx_pkg::ADDR_CONTROL, 32'h0000_0006);
        load(2'h3, 6'h16, 6'h00);
        repeat (1400) @(posedge hclk);
        chk("cont a", {31'h0, na >= 21}, 32'h1);
        rdchk("cont busy", feac_tx_pkg::ADDR_STATUS, 32'h0);
        // New code must not match the old one, so stale frames are not counted
        load(2'h1, 6'h0b, 6'h00);
        wait_idle();
        chk("abort a", 32'(na), 32'd10);
        load(2'h3, 6'h16, 6'h00);
        repeat (101) @(posedge hclk);
        xfer(feac_tx_pkg::ADDR_STICKY, 1'b1, 32'h1);
        load(2'h0, 6'h16, 6'h00);
        repeat (100) @(posedge hclk);
        chk("idle ones", {16'h0, window}, 32'hffff);
        rdchk("idle status", feac_tx_pkg::ADDR_STATUS, 32'h1);
        rdchk("idle sticky", feac_tx_pkg::ADDR_STICKY, 32'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
